// >>> logic/evt_irq_bank.sv
`timescale 1ns/1ns
module evt_irq_bank #(
  parameter int W = 8 // number of event flags
)(
  input wire logic ref_clk_in, // system clock
  input wire logic sys_rst_in, // async reset, active high
  input wire logic [W-1:0] evt_in, // one-cycle event pulses
  input wire logic [W-1:0] w1c_in, // clear pulses, one per flag
  input wire logic mask_wr_in, // mask write strobe
  input wire logic [W-1:0] mask_data_in, // new mask value
  output logic [W-1:0] status_out, // sticky flags
  output logic [W-1:0] mask_out, // mask, 1 keeps a flag off the interrupt
  output logic irq_out // level, high while an unmasked flag is set
);
  logic [W-1:0] stat_ff; // sticky flags
  logic [W-1:0] mask_ff; // mask register
  logic [W-1:0] nxt_stat; // next flags

  // a new event beats a clear in the same cycle
  assign nxt_stat = (stat_ff & ~w1c_in) | evt_in;

  // flag and mask storage
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      stat_ff <= '0;
      mask_ff <= W'(pin_cfg_pkg::MASK_RST);
    end
    else
    begin
      stat_ff <= nxt_stat;
      if (mask_wr_in)
        mask_ff <= mask_data_in;
    end
  end

  assign status_out = stat_ff;
  assign mask_out = mask_ff;
  assign irq_out = |(stat_ff & ~mask_ff);
endmodule

// >>> logic/lane_input_filter.sv
`timescale 1ns/1ns
module lane_input_filter #(
  parameter int LANES = 8, // lane count
  parameter int DEB_CYCLES = 16 // cycles a level must hold
)(
  input wire logic ref_clk_in, // system clock
  input wire logic sys_rst_in, // async reset, active high
  input wire logic [LANES-1:0] pin_async_in, // raw pin levels
  output logic [LANES-1:0] pin_sync_out, // pins after two flops
  input wire logic [LANES-1:0] level_in, // levels to debounce
  output logic [LANES-1:0] stable_out // debounced levels
);
  localparam int CW = $clog2(DEB_CYCLES + 1); // counter width

  // ==========================================================
  // synchroniser
  logic [LANES-1:0] meta_ff; // first stage, read only by sync_ff
  logic [LANES-1:0] sync_ff; // second stage

  // two flops per pin
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      // reset to the idle level of an active-low input, so no false edge follows reset
      meta_ff <= '1;
      sync_ff <= '1;
    end
    else
    begin
      meta_ff <= pin_async_in;
      sync_ff <= meta_ff;
    end
  end
  assign pin_sync_out = sync_ff;

  // ==========================================================
  // debounce, one counter per lane
  for (genvar i = 0; i < LANES; i++)
  begin : g_deb
    logic [CW-1:0] cnt_ff; // cycles the new level has held
    logic stable_ff; // accepted level
    wire logic differs = level_in[i] != stable_ff; // level moved
    wire logic done = cnt_ff == CW'(DEB_CYCLES - 1); // held long enough

    // count while the level differs, accept it when held
    always_ff @(posedge ref_clk_in or posedge sys_rst_in)
    begin
      if (sys_rst_in)
      begin
        cnt_ff <= '0;
        stable_ff <= 1'b0;
      end
      else if (differs && done)
      begin
        cnt_ff <= '0;
        stable_ff <= level_in[i];
      end
      else if (differs)
        cnt_ff <= cnt_ff + CW'(1);
      else
        cnt_ff <= '0;
    end
    assign stable_out[i] = stable_ff;
  end
endmodule

// >>> logic/pin_cfg_pkg.sv
package pin_cfg_pkg;
  // ==========================================================
  // sizes
  localparam int LANES = 8; // lanes held by this bank
  localparam int PAIRS = 4; // configuration registers, two lanes each
  localparam int CONV_LANES = 3; // lanes 0 to 2 have converter inputs
  localparam int HI_LANE_LSB = 4; // upper lane field starts here
  localparam int LANE_REG4 = 1; // lane that steers regulator four
  localparam int LANE_REG5 = 2; // lane that steers regulator five

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_PAIR_01 = 6'h15; // lanes 0 and 1
  localparam logic [5:0] IDX_PAIR_23 = 6'h16; // lanes 2 and 3
  localparam logic [5:0] IDX_PAIR_45 = 6'h17; // lanes 4 and 5
  localparam logic [5:0] IDX_PAIR_67 = 6'h18; // lanes 6 and 7
  localparam logic [5:0] IDX_EVT_STAT = 6'h20; // sticky event flags
  localparam logic [5:0] IDX_EVT_MASK = 6'h21; // event mask, 1 masks

  // ==========================================================
  // reset values and timing
  localparam logic [7:0] CFG_RST = 8'h11; // both lanes plain inputs
  localparam logic [7:0] MASK_RST = 8'hff; // all events masked
  localparam int DEB_CYCLES = 16; // debounce length in clock cycles

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    FN_ALT = 2'b00, // alternate function
    FN_IN = 2'b01, // general input
    FN_OD = 2'b11 ^ 2'b01, // open-drain general output
    FN_PP = 2'b11 // push-pull general output
  } lane_fn_t;

  typedef struct packed {
    logic mode; // output level or debounce and wake-up
    logic pol; // polarity and supply rail
    lane_fn_t fn; // function selector
  } lane_cfg_t;

  typedef struct packed {
    logic [LANES-1:0] out; // pin level when driven
    logic [LANES-1:0] oe; // pin driven
    logic [LANES-1:0] pull; // internal pull-up on
    logic [LANES-1:0] rail; // supply rail two selected
  } pad_ctrl_t;

  // lane is monitored as an input
  function automatic logic lane_watched(lane_cfg_t c, logic conv);
    return (c.fn == FN_IN) || ((c.fn == FN_ALT) && conv);
  endfunction
endpackage

// >>> logic/pin_config_bank.sv
`timescale 1ns/1ns
// Operation
// - selector picks alternate, input, open-drain, push-pull
// - polarity 0: active low, rail one, pull-up on open-drain
// - polarity 1: active high, rail two, external pull-up
// - output level follows mode bit
// - input mode 1 debounces and wakes
// - lane 0 converter input also debounces, wakes
// - lane 1 converter or regulator four input
// - lane 1 mode 0 drives regulator four
// - lane 1 mode 1 debounced, no regulator
// - lane 2 mode 0 drives regulator five
// - lane 2 mode 1 debounced, converter wakes
// - lanes 3 to 7 route touch signals
// - active edge sets flag, raises interrupt
module pin_config_bank #(
  parameter int DEB_CYCLES = pin_cfg_pkg::DEB_CYCLES // debounce cycles
)(
  input wire logic ref_clk_in, // 100 MHz clock
  input wire logic sys_rst_in, // async reset, active high
  input wire logic [7:0] avs_address_in, // byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data
  input wire logic [3:0] avs_byteenable_in, // byte lanes
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall
  input wire logic [7:0] pin_in, // pad levels, asynchronous
  output logic [7:0] pin_out, // pad drive level
  output logic [7:0] pin_oe_out, // pad driven
  output logic [7:0] pullup_en_out, // internal pull-up on
  output logic [7:0] rail_two_sel_out, // supply rail two selected
  input wire logic [2:0] conv_trip_in, // converter threshold levels
  output logic [2:0] conv_route_out, // converter inputs a, b, c routed
  output logic [4:0] touch_route_out, // y-, y+, x-, x+, reference routed
  output logic [7:0] general_input_out, // active state per lane
  output logic regulator_four_enable_out, // regulator four enable
  output logic regulator_five_enable_out, // regulator five enable
  output logic wake_out, // wake-up pulse
  output logic irq_out // interrupt level
);
  // ==========================================================
  // bus slave
  logic ack_ff; // second cycle of a request
  logic [31:0] rdata_ff; // captured read data
  logic [7:0] pair_ff [pin_cfg_pkg::PAIRS]; // configuration registers
  logic [7:0] nxt_rd; // selected read byte
  logic [7:0] stat_w; // event flags
  logic [7:0] mask_w; // event mask

  wire logic req = avs_read_in | avs_write_in; // request present
  wire logic [5:0] idx = avs_address_in[7:2]; // word index
  wire logic aligned = avs_address_in[1:0] == 2'b00; // word aligned
  wire logic wr_take = ack_ff & avs_write_in & avs_byteenable_in[0] & aligned;
  wire logic in_pairs = idx >= pin_cfg_pkg::IDX_PAIR_01 && idx <= pin_cfg_pkg::IDX_PAIR_67;
  wire logic [1:0] pair_sel = 2'(idx - pin_cfg_pkg::IDX_PAIR_01); // register
  wire logic mask_wr = wr_take && idx == pin_cfg_pkg::IDX_EVT_MASK; // mask write
  wire logic stat_wr = wr_take && idx == pin_cfg_pkg::IDX_EVT_STAT; // flag clear
  wire logic [7:0] w1c = stat_wr ? avs_writedata_in[7:0] : 8'h00; // clear bits

  // one wait cycle for every request
  assign avs_waitrequest_out = req & ~ack_ff;
  assign avs_readdata_out = rdata_ff;

  // read selection; unmapped words read zero
  always_comb
  begin
    nxt_rd = 8'h00;
    if (!aligned)
      nxt_rd = 8'h00;
    else if (in_pairs)
      nxt_rd = pair_ff[pair_sel];
    else if (idx == pin_cfg_pkg::IDX_EVT_STAT)
      nxt_rd = stat_w;
    else if (idx == pin_cfg_pkg::IDX_EVT_MASK)
      nxt_rd = mask_w;
  end

  // handshake and read capture
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= req & ~ack_ff;
      if (avs_read_in && !ack_ff)
        rdata_ff <= {24'h00_0000, nxt_rd};
    end
  end

  // configuration register writes
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      for (int k = 0; k < pin_cfg_pkg::PAIRS; k++)
        pair_ff[k] <= pin_cfg_pkg::CFG_RST;
    end
    else
    begin
      for (int k = 0; k < pin_cfg_pkg::PAIRS; k++)
        if (wr_take && aligned && in_pairs && pair_sel == 2'(k))
          pair_ff[k] <= avs_writedata_in[7:0];
    end
  end

  // ==========================================================
  // lane decode
  pin_cfg_pkg::lane_cfg_t cfg [8]; // per-lane fields
  wire logic [7:0] conv_pad = {5'b0_0000, conv_trip_in}; // converters by lane
  logic [7:0] pin_sync; // synchronised pins
  logic [7:0] stable; // debounced active levels
  logic [7:0] watch; // lane monitored
  logic [7:0] src; // monitored raw level
  logic [7:0] raw; // undebounced active state
  logic [7:0] eff; // active state after optional debounce
  logic [7:0] mode_vec; // mode bits
  logic [7:0] alt_sel; // alternate function routed
  logic [7:0] nxt_out; // next pad level
  logic [7:0] nxt_oe; // next pad enable
  logic [7:0] nxt_pull; // next pull-up
  logic [7:0] nxt_rail; // next rail choice

  // split each register into its two lanes
  for (genvar p = 0; p < pin_cfg_pkg::PAIRS; p++)
  begin : g_pair
    assign cfg[2*p] = pin_cfg_pkg::lane_cfg_t'(pair_ff[p][3:0]);
    assign cfg[2*p+1] = pin_cfg_pkg::lane_cfg_t'(pair_ff[p][pin_cfg_pkg::HI_LANE_LSB +: 4]);
  end

  for (genvar i = 0; i < 8; i++)
  begin : g_lane
    localparam logic CONV = i < pin_cfg_pkg::CONV_LANES; // has converter
    // lane 0 to 2 alternate input is the converter threshold
    assign watch[i] = pin_cfg_pkg::lane_watched(cfg[i], CONV);
    assign src[i] = (cfg[i].fn == pin_cfg_pkg::FN_IN) ? pin_sync[i] : conv_pad[i];
    // polarity picks the active level
    assign raw[i] = watch[i] & (cfg[i].pol ? src[i] : ~src[i]);
    // mode 1 takes the debounced level
    assign eff[i] = cfg[i].mode ? stable[i] : raw[i];
    assign mode_vec[i] = cfg[i].mode;
    assign alt_sel[i] = cfg[i].fn == pin_cfg_pkg::FN_ALT;
    // push-pull drives both levels, open-drain only low
    assign nxt_oe[i] = (cfg[i].fn == pin_cfg_pkg::FN_PP) ||
                       (cfg[i].fn == pin_cfg_pkg::FN_OD && !cfg[i].mode);
    assign nxt_out[i] = (cfg[i].fn == pin_cfg_pkg::FN_PP) && cfg[i].mode;
    assign nxt_pull[i] = (cfg[i].fn == pin_cfg_pkg::FN_OD) && !cfg[i].pol;
    assign nxt_rail[i] = cfg[i].pol;
  end

  // ==========================================================
  // input filter
  lane_input_filter #(
    .LANES(8),
    .DEB_CYCLES(DEB_CYCLES)
  ) u_filter (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .pin_async_in(pin_in),
    .pin_sync_out(pin_sync),
    .level_in(raw),
    .stable_out(stable)
  );

  // ==========================================================
  // pads, routes, regulators, events
  pin_cfg_pkg::pad_ctrl_t pad_ff; // registered pad controls
  logic [7:0] route_ff; // registered alternate routes
  logic [7:0] act_ff; // last active state, for edges
  logic reg4_ff; // regulator four enable
  logic reg5_ff; // regulator five enable
  logic wake_ff; // wake pulse
  logic [7:0] evt; // active-edge pulses

  // mode 0 on a regulator lane follows the undebounced input
  wire logic nxt_reg4 = cfg[pin_cfg_pkg::LANE_REG4].fn == pin_cfg_pkg::FN_IN &&
    !cfg[pin_cfg_pkg::LANE_REG4].mode && raw[pin_cfg_pkg::LANE_REG4];
  wire logic nxt_reg5 = cfg[pin_cfg_pkg::LANE_REG5].fn == pin_cfg_pkg::FN_IN &&
    !cfg[pin_cfg_pkg::LANE_REG5].mode && raw[pin_cfg_pkg::LANE_REG5];

  assign evt = eff & ~act_ff;

  // registered outputs
  always_ff @(posedge ref_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pad_ff <= '0;
      route_ff <= 8'h00;
      act_ff <= 8'h00;
      reg4_ff <= 1'b0;
      reg5_ff <= 1'b0;
      wake_ff <= 1'b0;
    end
    else
    begin
      pad_ff <= '{out: nxt_out, oe: nxt_oe, pull: nxt_pull, rail: nxt_rail};
      route_ff <= alt_sel;
      act_ff <= eff;
      reg4_ff <= nxt_reg4;
      reg5_ff <= nxt_reg5;
      wake_ff <= |(evt & mode_vec);
    end
  end

  // sticky flags and mask
  evt_irq_bank #(
    .W(8)
  ) u_irq (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .evt_in(evt),
    .w1c_in(w1c),
    .mask_wr_in(mask_wr),
    .mask_data_in(avs_writedata_in[7:0]),
    .status_out(stat_w),
    .mask_out(mask_w),
    .irq_out(irq_out)
  );

  assign pin_out = pad_ff.out;
  assign pin_oe_out = pad_ff.oe;
  assign pullup_en_out = pad_ff.pull;
  assign rail_two_sel_out = pad_ff.rail;
  assign conv_route_out = route_ff[2:0];
  assign touch_route_out = route_ff[7:3];
  assign general_input_out = act_ff;
  assign regulator_four_enable_out = reg4_ff;
  assign regulator_five_enable_out = reg5_ff;
  assign wake_out = wake_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  pp_drive_a: assert property (
    cfg[0].fn == pin_cfg_pkg::FN_PP |=> pin_oe_out[0] && pin_out[0] == $past(cfg[0].mode))
    else $error("push-pull lane not driving mode level");
  od_drive_a: assert property (
    cfg[0].fn == pin_cfg_pkg::FN_OD |=> !pin_out[0] && pin_oe_out[0] != $past(cfg[0].mode))
    else $error("open-drain lane drive wrong");
  input_float_a: assert property (
    (cfg[3].fn == pin_cfg_pkg::FN_IN || cfg[3].fn == pin_cfg_pkg::FN_ALT) |=> !pin_oe_out[3])
    else $error("input lane drives pad");
  pull_rail_a: assert property (
    ##1 rail_two_sel_out[0] == $past(cfg[0].pol) &&
    pullup_en_out[0] == $past(!cfg[0].pol && cfg[0].fn == pin_cfg_pkg::FN_OD))
    else $error("rail or pull-up wrong");
  // regulator enables follow the raw active state of their lane
  reg4_follow_a: assert property (
    (cfg[1].fn == pin_cfg_pkg::FN_IN && !cfg[1].mode)
    |=> regulator_four_enable_out == $past(pin_sync[1] == cfg[1].pol))
    else $error("regulator four not following input");
  reg5_follow_a: assert property (
    (cfg[2].fn == pin_cfg_pkg::FN_IN && !cfg[2].mode)
    |=> regulator_five_enable_out == $past(pin_sync[2] == cfg[2].pol))
    else $error("regulator five not following input");
  // undebounced input shows its active state one cycle later
  input_bypass_a: assert property (
    (cfg[5].fn == pin_cfg_pkg::FN_IN && !cfg[5].mode)
    |=> general_input_out[5] == $past(pin_sync[5] == cfg[5].pol))
    else $error("undebounced input state wrong");
  reg4_block_a: assert property (
    cfg[1].mode |=> !regulator_four_enable_out)
    else $error("regulator four driven in mode 1");
  reg5_block_a: assert property (
    (cfg[2].fn != pin_cfg_pkg::FN_IN || cfg[2].mode) |=> !regulator_five_enable_out)
    else $error("regulator five driven when not allowed");
  touch_route_a: assert property (
    cfg[3].fn == pin_cfg_pkg::FN_ALT |=> touch_route_out[0])
    else $error("touch route missing");
  touch_ref_a: assert property (
    cfg[7].fn == pin_cfg_pkg::FN_ALT |=> touch_route_out[4])
    else $error("touch reference route missing");
  conv_route_a: assert property (
    cfg[1].fn == pin_cfg_pkg::FN_ALT |=> conv_route_out[1])
    else $error("converter route missing");
  wake_gate_a: assert property (
    (evt != 8'h00 && (evt & mode_vec) == 8'h00) |=> !wake_out)
    else $error("wake without debounced lane");
  // a mask write in the same cycle may legally hide the event
  irq_raise_a: assert property (
    (evt[3] && !mask_w[3] && !mask_wr) |=> irq_out ##0 stat_w[3])
    else $error("unmasked event missed interrupt");
  // every edge lands in its flag, even against a clear
  flag_set_a: assert property (
    (evt != 8'h00) |=> (stat_w & $past(evt)) == $past(evt))
    else $error("event flag not set");
  bus_answer_a: assert property (
    (req && avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("bus answer late");

  reg4_on_c: cover property (!regulator_four_enable_out ##1 regulator_four_enable_out);
  wake_c: cover property (wake_out);
  irq_c: cover property (!irq_out ##1 irq_out);
  write_c: cover property (wr_take && in_pairs);
endmodule

// >>> sim/pad_world.sv
`timescale 1ns/1ns
// ==========================================================
// pad world: resolves each pad from device, outside source and pull-ups
module pad_world (
  input wire logic clk_in, // system clock
  input wire logic [7:0] drive_in, // device pad level
  input wire logic [7:0] oe_in, // device drives the pad
  input wire logic [7:0] pullup_in, // internal pull-up on
  input wire logic [7:0] ext_en_in, // outside source drives the pad
  input wire logic [7:0] ext_lvl_in, // outside source level
  output logic [7:0] level_out // resolved pad level
);
  logic [7:0] float_ff = 8'h55; // undriven pads wander
  logic [7:0] free_w; // pads nobody drives
  // an undriven pad without pull-up never holds its last value
  always @(posedge clk_in)
  begin
    float_ff <= ~float_ff;
  end
  assign free_w = ~oe_in & ~ext_en_in;
  // device wins, then outside source, then pull-up, else wandering
  assign level_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_lvl_in)
    | (free_w & pullup_in) | (free_w & ~pullup_in & float_ff);
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ns
module tb;
  // ==========================================================
  // signals
  logic ref_clk, sys_rst, avs_read, avs_write, avs_wait;
  logic [7:0] avs_address, rd, b;
  logic [31:0] avs_writedata, avs_readdata, cfg;
  logic [3:0] avs_be;
  logic [7:0] pin_level, pin_drv, pin_oe, pull_en, rail_two, gen_in, ext_en, ext_lvl;
  logic [2:0] conv_trip, conv_route;
  logic [4:0] touch_route;
  logic reg_four, reg_five, wake, irq;
  logic [7:0] route_all; // routing flag per lane
  logic [15:0] seed; // random state
  int err_count, checks, wake_cnt, w0;
  assign route_all = {touch_route, conv_route};

  // ==========================================================
  // design, short debounce, and the pads around it
  pin_config_bank #(.DEB_CYCLES(4)) DUT (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_byteenable_in(avs_be),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_wait),
    .pin_in(pin_level), .pin_out(pin_drv), .pin_oe_out(pin_oe),
    .pullup_en_out(pull_en), .rail_two_sel_out(rail_two), .conv_trip_in(conv_trip),
    .conv_route_out(conv_route), .touch_route_out(touch_route),
    .general_input_out(gen_in), .regulator_four_enable_out(reg_four),
    .regulator_five_enable_out(reg_five), .wake_out(wake), .irq_out(irq));
  pad_world partner (.clk_in(ref_clk), .drive_in(pin_drv), .oe_in(pin_oe),
    .pullup_in(pull_en), .ext_en_in(ext_en), .ext_lvl_in(ext_lvl), .level_out(pin_level));

  // ==========================================================
  // clock, wake pulse counter, watchdog
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    if (wake === 1'b1)
      wake_cnt <= wake_cnt + 1;
  end
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    report_and_stop();
  end

  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected {route, oe, level, pull-up, rail} of one lane
  function automatic logic [7:0] lane_pad(input logic [3:0] c);
    logic oe;
    oe = (c[1:0] == 2'b11) || (c[1:0] == 2'b10 && !c[3]);
    return {3'b000, c[1:0] == 2'b00, oe, oe & c[3], c[1:0] == 2'b10 && !c[2], c[2]};
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // one bus transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_be <= be;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge ref_clk);
    while (avs_wait !== 1'b0) @(posedge ref_clk);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'h1);
    cmp(rd, exp, "read");
  endtask
  task automatic check_pads(input logic [31:0] c);
    for (int i = 0; i < 8; i++)
      cmp({3'b000, route_all[i], pin_oe[i], pin_drv[i] & pin_oe[i], pull_en[i], rail_two[i]},
        lane_pad(c[i*4+:4]), "pad");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial
  begin
    {avs_read, avs_write, avs_address, avs_writedata, avs_be} = '0;
    {err_count, checks} = '0;
    sys_rst = 1'b1;
    ext_en = 8'hff;
    ext_lvl = 8'hff;
    conv_trip = 3'b000;
    seed = 16'hcd40;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    // reset values, refused accesses
    for (int k = 0; k < 4; k++)
      rdc(8'h54 + 8'(4 * k), 8'h11);
    rdc(8'h84, 8'hff);
    rdc(8'h80, 8'h00);
    rdc(8'h40, 8'h00);
    rdc(8'h55, 8'h00);
    bus(1'b1, 8'h54, 8'h00, 4'h0);
    rdc(8'h54, 8'h11);
    cmp(irq, 1'b0, "irq");
    $display("test reset done");
    // every function code, then random configurations and pad drives
    for (int it = 0; it < 10; it++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        seed = lfsr(seed);
        b = (it < 4) ? {2{it[1], it[0], it[1:0]}} : seed[7:0];
        cfg[k*8+:8] = b;
        wr(8'h54 + 8'(4 * k), b);
      end
      ext_en <= seed[15:8];
      ext_lvl <= seed[11:4];
      for (int k = 0; k < 4; k++)
        rdc(8'h54 + 8'(4 * k), cfg[k*8+:8]);
      repeat (2) @(posedge ref_clk);
      check_pads(cfg);
    end
    ext_en <= 8'hff;
    ext_lvl <= 8'h00;
    $display("test pads done");
    // lane 3 active high: short pulse, then a long hold, then masking
    for (int m = 0; m < 2; m++)
    begin
      // lane 2 active high and passive, so regulator five stays off
      wr(8'h58, {m[0], 3'b101, 4'h5});
      wr(8'h84, 8'hf7);
      repeat (4) @(posedge ref_clk);
      wr(8'h80, 8'hff);
      w0 = wake_cnt;
      ext_lvl[3] <= 1'b1;
      repeat (2) @(posedge ref_clk);
      ext_lvl[3] <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rdc(8'h80, m ? 8'h00 : 8'h08);
      cmp(irq, !m, "irq");
      ext_lvl[3] <= 1'b1;
      repeat (12) @(posedge ref_clk);
      cmp(gen_in[3], 1'b1, "input");
      rdc(8'h80, 8'h08);
      cmp(wake_cnt - w0, m, "wake");
      wr(8'h84, 8'hff);
      cmp(irq, 1'b0, "irq");
      wr(8'h80, 8'h08);
      rdc(8'h80, 8'h00);
      ext_lvl[3] <= 1'b0;
    end
    $display("test events done");
    // regulator inputs on lanes 1 and 2
    wr(8'h84, 8'hff);
    for (int l = 1; l < 3; l++)
      for (int m = 0; m < 2; m++)
      begin
        b = {m[0], 3'b101};
        wr(l == 1 ? 8'h54 : 8'h58, l == 1 ? {b[3:0], 4'h1} : {4'h1, b[3:0]});
        ext_lvl[l] <= 1'b1;
        repeat (5) @(posedge ref_clk);
        cmp({reg_five, reg_four}, m ? 2'b00 : 2'(l), "regulator");
        if (m == 0)
          repeat (10000) @(posedge ref_clk);
        ext_lvl[l] <= 1'b0;
        repeat (5) @(posedge ref_clk);
        cmp({reg_five, reg_four}, 2'b00, "regulator");
      end
    $display("test regulators done");
    // converter inputs of lanes 0 to 2, debounced with wake-up
    for (int l = 0; l < 3; l++)
    begin
      wr(8'h54, l == 1 ? 8'hc1 : (l == 0 ? 8'h1c : 8'h11));
      wr(8'h58, l == 2 ? 8'h1c : 8'h11);
      repeat (4) @(posedge ref_clk);
      wr(8'h80, 8'hff);
      w0 = wake_cnt;
      conv_trip[l] <= 1'b1;
      repeat (12) @(posedge ref_clk);
      rdc(8'h80, 8'h01 << l);
      cmp(wake_cnt - w0, 1, "wake");
      conv_trip[l] <= 1'b0;
    end
    $display("test converters done");
    report_and_stop();
  end
endmodule
